// File: sfrp_regs.svh
// register map, field positions and reset values of the paged register decode
// Operation
// - 8-bit read-only stack readout, resets to zero
// - readout decoded at 0xD3 on page F only
// - level index field selects readout stack entry
// - bit set/clear/test at low nibble 0x0, 0x8
// - unpaged registers answer on both pages
// - 0xB9 goes to converter 0 or 1 by page
// - all-pages registers like 0xE6 always decode
// - index 000 top through 100 bottom, others invalid
// - auto paging pushes on entry, pops on return
// - page select write sets page, read returns it
`ifndef SFRP_REGS_SVH
`define SFRP_REGS_SVH

// ----------------------------------------------------------------------------
// addresses
// ----------------------------------------------------------------------------
`define SFRP_ADDR_PAGE_SEL 8'hA7
`define SFRP_ADDR_PAGE_CTRL 8'hCF
`define SFRP_ADDR_STACK 8'hD3
`define SFRP_ADDR_CONV 8'hB9
`define SFRP_ADDR_EXT_IRQ_ENABLE_FIRST 8'hE6

// ----------------------------------------------------------------------------
// page codes, fields and reset values
// ----------------------------------------------------------------------------
`define SFRP_PAGE_0 8'h00
`define SFRP_PAGE_F 8'h0F
`define SFRP_PAGE_SEL_RST 8'h00
`define SFRP_PAGE_CTRL_RST 8'h01
`define SFRP_STACK_RST 8'h00
`define SFRP_CTRL_MASK 8'h71
`define SFRP_IDX_LSB 4
`define SFRP_IDX_MSB 6
`define SFRP_AUTO_EN_BIT 0
`define SFRP_IDX_TOP 3'h0
`define SFRP_IDX_BOTTOM 3'h4
`define SFRP_BITADDR_A 4'h0
`define SFRP_BITADDR_B 4'h8

`endif

// File: sfrp_pkg.sv
// types shared by the paged register decode and its page stack
package sfrp_pkg;
  // single-bit operation requested by the core
  typedef enum logic [1:0] {
    SFRP_BIT_NONE = 2'h0,
    SFRP_BIT_SET = 2'h1,
    SFRP_BIT_CLR = 2'h2,
    SFRP_BIT_TEST = 2'h3
  } sfrp_bitop_t;
  // one register byte
  typedef logic [7:0] sfrp_byte_t;
  // stack level index
  typedef logic [2:0] sfrp_idx_t;
endpackage

// File: sfrp_page_stack.sv
// four saved page levels below the current page, with registered readout
`timescale 1ns/1ns
`include "sfrp_regs.svh"
module sfrp_page_stack #(
  parameter int DEPTH = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire sfrp_pkg::sfrp_byte_t cur_page,
  input wire sfrp_pkg::sfrp_idx_t idx,
  output sfrp_pkg::sfrp_byte_t restore,
  output sfrp_pkg::sfrp_byte_t rd_q
);
  // ----------------------------------------------------------------------
  // storage: level 0 is the live page register, kept by the parent
  // ----------------------------------------------------------------------
  sfrp_pkg::sfrp_byte_t lvl_q [1:DEPTH-1]; // saved pages, 1 is newest

  // push shifts down and drops the bottom; pop shifts up and clears bottom
  // stack push and pop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 1; i < DEPTH; i++) begin
        lvl_q[i] <= `SFRP_STACK_RST;
      end
    end else if (push) begin
      lvl_q[1] <= cur_page;
      for (int i = 2; i < DEPTH; i++) begin
        lvl_q[i] <= lvl_q[i-1];
      end
    end else if (pop) begin
      for (int i = 1; i < DEPTH - 1; i++) begin
        lvl_q[i] <= lvl_q[i+1];
      end
      lvl_q[DEPTH-1] <= `SFRP_STACK_RST;
    end
  end

  // page handed back on interrupt return
  assign restore = lvl_q[1];

  // readout register, follows the index one cycle later
  // level decode, invalid codes read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q <= `SFRP_STACK_RST;
    end else if (idx == `SFRP_IDX_TOP) begin
      rd_q <= cur_page;
    end else if (idx <= `SFRP_IDX_BOTTOM) begin
      rd_q <= lvl_q[idx];
    end else begin
      rd_q <= `SFRP_STACK_RST;
    end
  end
endmodule

// File: sfrp_decode.sv
// paged register decode, page select, page control and stack readout
`timescale 1ns/1ns
`include "sfrp_regs.svh"
module sfrp_decode (
  input wire logic clk,
  input wire logic rst_n,
  input wire sfrp_pkg::sfrp_byte_t sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire sfrp_pkg::sfrp_byte_t sfr_wdata,
  input wire sfrp_pkg::sfrp_bitop_t sfr_bit_op,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic irq_entry,
  input wire sfrp_pkg::sfrp_byte_t irq_page,
  input wire logic irq_return,
  output sfrp_pkg::sfrp_byte_t rdata_q,
  output logic rd_hit_q,
  output logic bit_q,
  output sfrp_pkg::sfrp_byte_t cur_page_q,
  output logic auto_page_enable,
  output logic bit_addr_ok,
  output logic sel_all_pages,
  output logic sel_page0_only,
  output logic sel_pagef_only,
  output logic sel_conv0,
  output logic sel_conv1,
  output logic sel_ext_irq_en1,
  output logic sel_stack_readout
);
  // every check below runs on the one clock and sleeps during reset
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // addresses that hold one register on page 0 and another on page F
  function automatic logic is_paged(input logic [7:0] a);
    case (a)
      8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97: is_paged = 1'b1;
      8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hB9: is_paged = 1'b1;
      8'hC0, 8'hC1, 8'hC2, 8'hC8, 8'hCA, 8'hCB: is_paged = 1'b1;
      8'hCC, 8'hCD, 8'hD2, 8'hD3, 8'hD7, 8'hE7: is_paged = 1'b1;
      default: is_paged = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  sfrp_pkg::sfrp_byte_t ctrl_q; // page control, reserved bits held zero
  sfrp_pkg::sfrp_idx_t idx; // stack level index field
  sfrp_pkg::sfrp_byte_t restore; // newest saved page
  sfrp_pkg::sfrp_byte_t stack_rd; // registered stack readout
  sfrp_pkg::sfrp_byte_t rd_val; // value of the addressed own register
  logic on_page0; // page 0 is current
  logic on_pagef; // page F is current
  logic do_push; // automatic push this cycle
  logic do_pop; // automatic pop this cycle
  logic own_hit; // address is one of ours

  assign idx = ctrl_q[`SFRP_IDX_MSB:`SFRP_IDX_LSB];
  assign auto_page_enable = ctrl_q[`SFRP_AUTO_EN_BIT];
  assign on_page0 = cur_page_q == `SFRP_PAGE_0;
  assign on_pagef = cur_page_q == `SFRP_PAGE_F;
  // entry wins over return if both arrive together
  assign do_push = auto_page_enable & irq_entry;
  assign do_pop = auto_page_enable & irq_return & ~irq_entry;

  // ----------------------------------------------------------------------
  // page selection decode
  // ----------------------------------------------------------------------
  // unpaged addresses answer on either page
  assign sel_all_pages = ~is_paged(sfr_addr);
  assign sel_page0_only = is_paged(sfr_addr) & on_page0;
  assign sel_pagef_only = is_paged(sfr_addr) & on_pagef;
  assign sel_conv0 = (sfr_addr == `SFRP_ADDR_CONV) & on_page0;
  assign sel_conv1 = (sfr_addr == `SFRP_ADDR_CONV) & on_pagef;
  assign sel_ext_irq_en1 = sfr_addr == `SFRP_ADDR_EXT_IRQ_ENABLE_FIRST;
  assign sel_stack_readout = (sfr_addr == `SFRP_ADDR_STACK) & on_pagef;
  assign bit_addr_ok = (sfr_addr[3:0] == `SFRP_BITADDR_A) |
                       (sfr_addr[3:0] == `SFRP_BITADDR_B);

  // ----------------------------------------------------------------------
  // current page register
  // ----------------------------------------------------------------------
  // interrupt paging wins over a core write in the same cycle
  // load interrupt page or restore
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_page_q <= `SFRP_PAGE_SEL_RST;
    end else if (do_push) begin
      cur_page_q <= irq_page;
    end else if (do_pop) begin
      cur_page_q <= restore;
    end else if (sfr_wr && sfr_addr == `SFRP_ADDR_PAGE_SEL) begin
      cur_page_q <= sfr_wdata;
    end
  end

  // page control; reserved bits cannot be set so they read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `SFRP_PAGE_CTRL_RST;
    end else if (sfr_wr && sfr_addr == `SFRP_ADDR_PAGE_CTRL) begin
      ctrl_q <= sfr_wdata & `SFRP_CTRL_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // page stack
  // ----------------------------------------------------------------------
  // index steers readout
  sfrp_page_stack #(
    .DEPTH(5)
  ) u_stack (
    .clk(clk),
    .rst_n(rst_n),
    .push(do_push),
    .pop(do_pop),
    .cur_page(cur_page_q),
    .idx(idx),
    .restore(restore),
    .rd_q(stack_rd)
  );

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // own registers only; other addresses are answered by their peripherals
  always_comb begin
    rd_val = 8'h00;
    own_hit = 1'b1;
    if (sfr_addr == `SFRP_ADDR_PAGE_SEL) begin
      // read back the page in use
      rd_val = cur_page_q;
    end else if (sfr_addr == `SFRP_ADDR_PAGE_CTRL) begin
      rd_val = ctrl_q;
    end else if (sel_stack_readout) begin
      rd_val = stack_rd;
    end else begin
      own_hit = 1'b0;
    end
  end

  // read data held until the next read, bit test result until the next bit test read at a bit address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rd_hit_q <= 1'b0;
      bit_q <= 1'b0;
    end else if (sfr_rd) begin
      rdata_q <= rd_val;
      rd_hit_q <= own_hit;
      if (sfr_bit_op == sfrp_pkg::SFRP_BIT_TEST && bit_addr_ok) begin
        bit_q <= rd_val[sfr_bit_sel];
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_page_write;
    sfr_wr && sfr_addr == `SFRP_ADDR_PAGE_SEL && !do_push && !do_pop;
  endsequence
  sequence s_page_read;
    sfr_rd && sfr_addr == `SFRP_ADDR_PAGE_SEL;
  endsequence
  sequence s_invalid_read;
    sfr_rd && sel_stack_readout && idx > `SFRP_IDX_BOTTOM &&
      $past(idx) > `SFRP_IDX_BOTTOM;
  endsequence
  // page quiet before and at the read, so the lagging readout caught up
  sequence s_top_read;
    sfr_rd && sel_stack_readout && idx == `SFRP_IDX_TOP &&
      $past(idx) == `SFRP_IDX_TOP && $stable(cur_page_q) &&
      !do_push && !do_pop && !sfr_wr;
  endsequence
  // reads of addresses that peripherals answer, not this block
  sequence s_foreign_read;
    sfr_rd && sfr_addr != `SFRP_ADDR_PAGE_SEL &&
      sfr_addr != `SFRP_ADDR_PAGE_CTRL && !sel_stack_readout;
  endsequence
  // with paging off only a software write may move the page
  sequence s_quiet_page;
    !auto_page_enable && !(sfr_wr && sfr_addr == `SFRP_ADDR_PAGE_SEL);
  endsequence

  a_page_write: assert property (
    s_page_write |=> cur_page_q == $past(sfr_wdata))
    else $error("page write not taken");
  a_page_read: assert property (
    s_page_read |=> rdata_q == $past(cur_page_q) && rd_hit_q)
    else $error("page select read back wrong");
  a_push_load: assert property (
    do_push |=> cur_page_q == $past(irq_page))
    else $error("interrupt page not loaded");
  a_push_pop: assert property (
    (do_push ##1 do_pop) |=> cur_page_q == $past(cur_page_q, 2))
    else $error("page not restored on return");
  a_auto_off: assert property (
    s_quiet_page |=> $stable(cur_page_q))
    else $error("page moved with auto paging off");
  a_conv_route: assert property (
    sfr_addr == `SFRP_ADDR_CONV |-> sel_conv0 == on_page0 &&
      sel_conv1 == on_pagef)
    else $error("converter control misrouted");
  a_ext_irq_enable_first_pages: assert property (
    sfr_addr == `SFRP_ADDR_EXT_IRQ_ENABLE_FIRST |-> sel_ext_irq_en1 && sel_all_pages)
    else $error("all-pages register not decoded");
  a_stack_decode: assert property (
    sel_stack_readout |-> sfr_addr == `SFRP_ADDR_STACK && on_pagef)
    else $error("readout decoded off page F");
  a_foreign_read: assert property (
    s_foreign_read |=> rdata_q == 8'h00 && !rd_hit_q)
    else $error("foreign address answered by this block");
  a_invalid_zero: assert property (
    s_invalid_read |=> rdata_q == 8'h00 && rd_hit_q)
    else $error("invalid index returned data");
  a_top_current: assert property (
    s_top_read |=> rdata_q == cur_page_q)
    else $error("top level is not current page");
  a_bit_nibble: assert property (
    bit_addr_ok |-> sfr_addr[2:0] == 3'h0)
    else $error("bit access outside nibble 0 or 8");
endmodule

// File: sfrp_core_model.sv
// core-side register bus model issuing reads, writes and address holds
`timescale 1ns/1ns
module sfrp_core_model (
  input wire logic clk,
  output sfrp_pkg::sfrp_byte_t sfr_addr,
  output logic sfr_rd,
  output logic sfr_wr,
  output sfrp_pkg::sfrp_byte_t sfr_wdata,
  output sfrp_pkg::sfrp_bitop_t sfr_bit_op,
  output logic [2:0] sfr_bit_sel
);
  // ---------------------------------------------
  // idle bus at time zero
  // ---------------------------------------------
  initial begin
    sfr_addr = 8'h00;
    sfr_rd = 1'b0;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    // bit ops stay idle except during a bit test read
    sfr_bit_op = sfrp_pkg::SFRP_BIT_NONE;
    sfr_bit_sel = 3'h0;
  end
  // one strobed cycle; released lines show the inverse, never stale data
  task automatic cyc(input logic w, input sfrp_pkg::sfrp_byte_t a,
                     input sfrp_pkg::sfrp_byte_t d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= w;
    sfr_rd <= !w;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
  endtask
  // address only, no strobe, for looking at the decode selects
  task automatic put(input sfrp_pkg::sfrp_byte_t a);
    @(posedge clk);
    sfr_addr <= a;
    #1;
  endtask
  // bit test read: op and bit number qualify the one read strobe
  task automatic bit_rd(input sfrp_pkg::sfrp_byte_t a, input logic [2:0] b);
    @(posedge clk);
    sfr_addr <= a;
    sfr_bit_op <= sfrp_pkg::SFRP_BIT_TEST;
    sfr_bit_sel <= b;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    sfr_bit_op <= sfrp_pkg::SFRP_BIT_NONE;
    sfr_addr <= ~a;
  endtask
endmodule

// File: sfr_page_stack_and_paged_decode_tb.sv
// self-checking bench for the paged decode and page stack readout
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module sfr_page_stack_and_paged_decode_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_entry = 1'b0;
  logic irq_return = 1'b0;
  sfrp_pkg::sfrp_byte_t irq_page = 8'h00;
  sfrp_pkg::sfrp_byte_t sfr_addr, sfr_wdata, rdata_q, cur_page_q, pg;
  sfrp_pkg::sfrp_bitop_t sfr_bit_op;
  logic [2:0] sfr_bit_sel;
  logic sfr_rd, sfr_wr, rd_hit_q, auto_page_enable, sel_conv0, sel_conv1;
  logic sel_ext_irq_en1, sel_stack_readout, bit_addr_ok;
  logic sel_all_pages, sel_page0_only, sel_pagef_only, bit_q;
  logic [31:0] seed = 32'h0000_0060;
  int compares = 0;
  int bad_count = 0;
  sfrp_pkg::sfrp_byte_t r [4];
  sfrp_pkg::sfrp_byte_t e [8];
  sfrp_pkg::sfrp_byte_t a, p2;
  initial begin
    forever #25 clk = ~clk;
  end
  sfrp_core_model u_sfrp_core_model (.clk(clk), .sfr_addr(sfr_addr),
    .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_bit_op(sfr_bit_op), .sfr_bit_sel(sfr_bit_sel));
  sfrp_decode u_sfrp_decode (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_bit_op(sfr_bit_op), .sfr_bit_sel(sfr_bit_sel),
    .irq_entry(irq_entry), .irq_page(irq_page), .irq_return(irq_return),
    .rdata_q(rdata_q), .rd_hit_q(rd_hit_q), .bit_q(bit_q),
    .cur_page_q(cur_page_q), .auto_page_enable(auto_page_enable),
    .bit_addr_ok(bit_addr_ok), .sel_all_pages(sel_all_pages),
    .sel_page0_only(sel_page0_only), .sel_pagef_only(sel_pagef_only),
    .sel_conv0(sel_conv0), .sel_conv1(sel_conv1),
    .sel_ext_irq_en1(sel_ext_irq_en1), .sel_stack_readout(sel_stack_readout));
  // xorshift source, fixed start so every run repeats
  function logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // addresses the map gives two registers, one on each page
  function automatic logic paged(input sfrp_pkg::sfrp_byte_t x);
    return (x >= 8'h91 && x <= 8'h97) || (x >= 8'hAB && x <= 8'hAE) ||
      x == 8'hB9 || (x >= 8'hC0 && x <= 8'hC2) || x == 8'hC8 ||
      (x >= 8'hCA && x <= 8'hCD) || x == 8'hD2 || x == 8'hD3 ||
      x == 8'hD7 || x == 8'hE7;
  endfunction
  // read through the core model and compare the registered answer
  task automatic rd_chk(input sfrp_pkg::sfrp_byte_t ad,
                        input sfrp_pkg::sfrp_byte_t ex, input logic h);
    u_sfrp_core_model.cyc(1'b0, ad, 8'h00);
    #1;
    `CHK(rdata_q, ex)
    `CHK(rd_hit_q, h)
  endtask
  // one-cycle interrupt entry or return pulse
  task automatic irq(input logic ent, input sfrp_pkg::sfrp_byte_t p);
    @(posedge clk);
    irq_entry <= ent;
    irq_return <= !ent;
    irq_page <= p;
    @(posedge clk);
    irq_entry <= 1'b0;
    irq_return <= 1'b0;
    irq_page <= ~p;
    #1;
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'hA7, 8'h00, 1'b1);
    rd_chk(8'hCF, 8'h01, 1'b1);
    rd_chk(8'hD3, 8'h00, 1'b0);
    $display("test reset done");
    // decode sweep: corner addresses first, then random ones on both pages
    for (int i = 0; i < 40; i++) begin
      a = (i < 3) ? ((i == 0) ? 8'hB9 : (i == 1) ? 8'hE6 : 8'hD3) :
        8'(nxt());
      pg = nxt() & 1 ? 8'h0F : 8'h00;
      u_sfrp_core_model.cyc(1'b1, 8'hA7, pg);
      u_sfrp_core_model.put(a);
      `CHK(sel_conv0, a == 8'hB9 && pg == 8'h00)
      `CHK(sel_conv1, a == 8'hB9 && pg == 8'h0F)
      `CHK(sel_ext_irq_en1, a == 8'hE6)
      `CHK(sel_stack_readout, a == 8'hD3 && pg == 8'h0F)
      `CHK(bit_addr_ok, a[3:0] == 4'h0 || a[3:0] == 4'h8)
      `CHK(sel_all_pages, !paged(a))
      `CHK(sel_page0_only, paged(a) && pg == 8'h00)
      `CHK(sel_pagef_only, paged(a) && pg == 8'h0F)
      rd_chk(8'hD3, pg == 8'h0F ? 8'h0F : 8'h00, pg == 8'h0F);
      rd_chk(8'hA7, pg, 1'b1);
      // the page register is not bit addressable, so a test is ignored
      u_sfrp_core_model.bit_rd(8'hA7, 3'(nxt() & 3));
      #1;
      `CHK(bit_q, 1'b0)
    end
    $display("test decode done");
    u_sfrp_core_model.cyc(1'b1, 8'hA7, 8'h00);
    // four entries fill the saved levels; page 0 sinks to the bottom
    for (int k = 0; k < 4; k++) begin
      r[k] = 8'(nxt());
      irq(1'b1, r[k]);
      `CHK(cur_page_q, r[k])
    end
    u_sfrp_core_model.cyc(1'b1, 8'hA7, 8'h0F);
    for (int k = 0; k < 8; k++) begin
      e[k] = (k == 0) ? 8'h0F : (k < 4) ? r[3-k] : 8'h00;
      u_sfrp_core_model.cyc(1'b1, 8'hCF, {1'b0, 3'(k), 4'h1});
      @(posedge clk);
      rd_chk(8'hD3, e[k], 1'b1);
    end
    u_sfrp_core_model.cyc(1'b1, 8'hCF, 8'h01);
    // pops restore the saved pages newest first, so the stack stayed intact
    for (int k = 1; k < 5; k++) begin
      irq(1'b0, 8'h00);
      `CHK(cur_page_q, e[k])
    end
    $display("test stack done");
    // entry then return on the very next edge hands the old page back
    u_sfrp_core_model.cyc(1'b1, 8'hA7, 8'h0F);
    p2 = 8'(nxt()) | 8'h10;
    @(posedge clk);
    irq_entry <= 1'b1;
    irq_page <= p2;
    @(posedge clk);
    irq_entry <= 1'b0;
    irq_return <= 1'b1;
    @(posedge clk);
    irq_return <= 1'b0;
    #1;
    `CHK(cur_page_q, 8'h0F)
    // page F is saved below p2, so a wrongly taken return would show it
    irq(1'b1, p2);
    `CHK(cur_page_q, p2)
    // with auto paging off neither entry nor return moves the page
    u_sfrp_core_model.cyc(1'b1, 8'hCF, 8'h00);
    #1;
    `CHK(auto_page_enable, 1'b0)
    irq(1'b1, ~p2);
    `CHK(cur_page_q, p2)
    irq(1'b0, 8'h00);
    `CHK(cur_page_q, p2)
    $display("test auto off done");
    // reset in mid-run clears page, saved levels and read flags and returns control to 0x01
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(cur_page_q, 8'h00)
    `CHK(rdata_q, 8'h00)
    `CHK(rd_hit_q, 1'b0)
    `CHK(auto_page_enable, 1'b1)
    u_sfrp_core_model.cyc(1'b1, 8'hA7, 8'h0F);
    u_sfrp_core_model.cyc(1'b1, 8'hCF, 8'h11);
    @(posedge clk);
    rd_chk(8'hD3, 8'h00, 1'b1);
    $display("test reset again done");
    wrap_up();
  end
endmodule
